//--- rtl/xas_top.sv
module xas_top (
  input wire logic mclk,
  input wire logic rst_n,
  // External-access pin, asynchronous to mclk
  input wire logic external_access_pin,
  // Write of the system control bits
  input wire logic ctl_wr,
  input wire logic ctl_disable_wdata,
  input wire logic ctl_visible_wdata,
  input wire logic ctl_map_wdata,
  // Write of the page register
  input wire logic page_wr,
  input wire logic [xas_pkg::BYTE_W-1:0] page_wdata,
  // Write of the pointer select
  input wire logic psel_wr,
  input wire logic [xas_pkg::PSEL_W-1:0] psel_wdata,
  // Load of the currently selected data pointer
  input wire logic ptr_wr,
  input wire logic [xas_pkg::ADDR_W-1:0] ptr_wdata,
  // Move request from the core
  input wire logic move_req,
  input wire logic move_use_ptr,
  input wire logic move_write,
  input wire logic [xas_pkg::BYTE_W-1:0] move_index,
  // Special register access request from the core
  input wire logic sfr_req,
  input wire logic [xas_pkg::BYTE_W-1:0] sfr_addr,
  // Move decision, valid for one cycle with move_done
  output logic move_done,
  output logic [xas_pkg::ADDR_W-1:0] move_addr,
  output logic move_onchip,
  output logic low_port_bus,
  output logic high_port_bus,
  output logic rd_strobe_active,
  output logic wr_strobe_active,
  // Special register routing, valid for one cycle with sfr_done
  output logic sfr_done,
  output logic sfr_to_mapped,
  output logic sfr_to_standard,
  output logic sfr_no_target,
  // Control state seen by software
  output logic onchip_xdata_disable,
  output logic onchip_xdata_visible,
  output logic sfr_map_select,
  output logic [xas_pkg::BYTE_W-1:0] xdata_page_register,
  output logic [xas_pkg::PSEL_W-1:0] pointer_select_register,
  output logic [xas_pkg::ADDR_W-1:0] data_pointer,
  output logic external_access_sync,
  // Internal reset after synchronisation
  output logic core_rst_n
);
  import xas_pkg::*;

  // Reset synchroniser chain
  logic [SYNC_STAGES-1:0] rst_sync_q;
  // External-access pin synchroniser stages
  logic ea_meta_q;
  logic ea_sync_q;

  // Control bits
  logic disable_q;
  logic disable_d;
  logic visible_q;
  logic visible_d;
  logic map_q;
  logic map_d;
  // Page register
  logic [BYTE_W-1:0] page_q;
  logic [BYTE_W-1:0] page_d;
  // Pointer select
  logic [PSEL_W-1:0] psel_q;
  logic [PSEL_W-1:0] psel_d;
  // Value of the selected pointer, straight from the bank
  logic [ADDR_W-1:0] bank_rdata;
  // Registered copy of the selected pointer
  logic [ADDR_W-1:0] ptr_view_q;

  // Registered move outputs
  logic move_done_q;
  logic [ADDR_W-1:0] move_addr_q;
  logic move_onchip_q;
  logic low_bus_q;
  logic high_bus_q;
  logic rd_act_q;
  logic wr_act_q;
  // Registered special register routing
  logic sfr_done_q;
  logic sfr_mapped_q;
  logic sfr_standard_q;
  logic sfr_none_q;

  // Internal reset, released by the synchroniser
  wire logic rst_int_n;

  // Reset is asserted at once and released two edges later, so
  // no flop sees a release in the middle of a clock edge.
  // The source must hold the pin low long enough for the core
  // around this block to settle as well.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[SYNC_STAGES-1];

  // Two-stage synchroniser on the external-access pin
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ea_meta_q <= 1'b0;
      ea_sync_q <= 1'b0;
    end else begin
      ea_meta_q <= external_access_pin;
      ea_sync_q <= ea_meta_q;
    end
  end

  // Next value of the disable bit: a write may only clear it,
  // a one written after clearing is dropped until reset
  assign disable_d = ctl_wr ? (disable_q & ctl_disable_wdata) : disable_q;
  // Next value of the visibility bit
  assign visible_d = ctl_wr ? ctl_visible_wdata : visible_q;
  // Map select holds its value until software writes it again
  assign map_d = ctl_wr ? ctl_map_wdata : map_q;
  // Next value of the page register
  assign page_d = page_wr ? page_wdata : page_q;
  // Next value of the pointer select
  assign psel_d = psel_wr ? psel_wdata : psel_q;

  // Control registers; disable comes up set after reset
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      disable_q <= DISABLE_RST;
      visible_q <= VISIBLE_RST;
      map_q <= MAP_SEL_RST;
    end else begin
      disable_q <= disable_d;
      visible_q <= visible_d;
      map_q <= map_d;
    end
  end

  // Page register and pointer select
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      page_q <= PAGE_RST;
      psel_q <= PSEL_RST;
    end else begin
      page_q <= page_d;
      psel_q <= psel_d;
    end
  end

  // Pointer bank; only the selected entry is loaded and read
  xas_pointer_bank u_ptr_bank (
    .mclk(mclk),
    .rst_n(rst_int_n),
    .sel(psel_q),
    .wr(ptr_wr),
    .wdata(ptr_wdata),
    .rdata(bank_rdata)
  );

  // Address of the move: full pointer, or page above index
  wire logic [ADDR_W-1:0] addr_ptr;
  wire logic [ADDR_W-1:0] addr_idx;
  wire logic [ADDR_W-1:0] addr_sel;
  assign addr_ptr = bank_rdata;
  assign addr_idx = {page_q, move_index};
  assign addr_sel = move_use_ptr ? addr_ptr : addr_idx;

  // Range checks; the top of the range is the top of the space
  wire logic ptr_in_range;
  wire logic page_in_range;
  wire logic in_range;
  assign ptr_in_range = (addr_ptr >= ONCHIP_START);
  assign page_in_range = (page_q >= ONCHIP_PAGE_START);
  assign in_range = move_use_ptr ? ptr_in_range : page_in_range;

  // On-chip target only while enabled and inside the range;
  // below the range the move goes out in every mode
  wire logic hit_onchip;
  assign hit_onchip = !disable_q && in_range;

  // Visible mode: ports and strobes show on-chip transfers
  wire logic show_onchip;
  assign show_onchip = hit_onchip && visible_q;

  // Quiet on-chip access with the pin high leaves ports as I/O;
  // with the pin low the low port still carries the data
  wire logic quiet_pin_high;
  assign quiet_pin_high = hit_onchip && !visible_q && ea_sync_q;

  // Low port drives the bus except for quiet accesses, pin high
  wire logic low_bus;
  assign low_bus = !quiet_pin_high;

  // High port drives the bus only for pointer moves; index moves
  // leave it as I/O so its port latch keeps its value
  wire logic high_bus;
  assign high_bus = move_use_ptr && low_bus;

  // Strobes fire for external targets and for visible mode only
  wire logic strobes_on;
  assign strobes_on = !hit_onchip || show_onchip;

  // Split the strobe by direction of the move
  wire logic rd_on;
  wire logic wr_on;
  assign rd_on = strobes_on && !move_write;
  assign wr_on = strobes_on && move_write;

  // Move decision registers, one cycle per request
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      move_done_q <= 1'b0;
      move_addr_q <= '0;
      move_onchip_q <= 1'b0;
      low_bus_q <= 1'b0;
      high_bus_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end else begin
      move_done_q <= move_req;
      move_addr_q <= move_req ? addr_sel : move_addr_q;
      move_onchip_q <= move_req && hit_onchip;
      low_bus_q <= move_req && low_bus;
      high_bus_q <= move_req && high_bus;
      rd_act_q <= move_req && rd_on;
      wr_act_q <= move_req && wr_on;
    end
  end

  // Special register decode: the mapped area holds two registers
  wire logic addr_is_mapped;
  assign addr_is_mapped = (sfr_addr == AUX_PWR_CTRL_ADDR) ||
                          (sfr_addr == PORT5_DIR_ADDR);
  // Map select picks the area for every access
  wire logic route_mapped;
  wire logic route_standard;
  wire logic route_none;
  assign route_mapped = map_q && addr_is_mapped;
  assign route_standard = !map_q;
  // With map select set, other addresses reach nothing at all
  assign route_none = map_q && !addr_is_mapped;

  // Routing registers, one cycle per request
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      sfr_done_q <= 1'b0;
      sfr_mapped_q <= 1'b0;
      sfr_standard_q <= 1'b0;
      sfr_none_q <= 1'b0;
    end else begin
      sfr_done_q <= sfr_req;
      sfr_mapped_q <= sfr_req && route_mapped;
      sfr_standard_q <= sfr_req && route_standard;
      sfr_none_q <= sfr_req && route_none;
    end
  end

  // Registered view of the selected pointer; lags a write by one
  // cycle, a trade for keeping every output on a flop
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ptr_view_q <= PTR_RST;
    end else begin
      ptr_view_q <= bank_rdata;
    end
  end

  // Output assignments, all from flops
  assign move_done = move_done_q;
  assign move_addr = move_addr_q;
  assign move_onchip = move_onchip_q;
  assign low_port_bus = low_bus_q;
  assign high_port_bus = high_bus_q;
  assign rd_strobe_active = rd_act_q;
  assign wr_strobe_active = wr_act_q;
  assign sfr_done = sfr_done_q;
  assign sfr_to_mapped = sfr_mapped_q;
  assign sfr_to_standard = sfr_standard_q;
  assign sfr_no_target = sfr_none_q;
  assign onchip_xdata_disable = disable_q;
  assign onchip_xdata_visible = visible_q;
  assign sfr_map_select = map_q;
  assign xdata_page_register = page_q;
  assign pointer_select_register = psel_q;
  assign data_pointer = ptr_view_q;
  assign external_access_sync = ea_sync_q;
  assign core_rst_n = rst_sync_q[SYNC_STAGES-1];

endmodule

//--- rtl/xas_pkg.sv
// Shared constants of the external-data steering block
package xas_pkg;

  // Width of the 16-bit external data address
  localparam int ADDR_W = 16;
  // Width of the 8-bit index register and page register
  localparam int BYTE_W = 8;
  // Number of selectable data pointers
  localparam int PTR_COUNT = 8;
  // Width of the pointer-select value
  localparam int PSEL_W = 3;

  // First address of the on-chip expansion RAM and CAN range
  localparam logic [15:0] ONCHIP_START = 16'hF700;
  // Upper byte of the range start, used for the page compare
  localparam logic [7:0] ONCHIP_PAGE_START = ONCHIP_START[15:8];

  // Values after reset of the control bits
  localparam logic DISABLE_RST = 1'b1;
  localparam logic VISIBLE_RST = 1'b0;
  localparam logic MAP_SEL_RST = 1'b0;
  // Value after reset of the page register
  localparam logic [7:0] PAGE_RST = 8'h00;
  // Value after reset of the pointer select
  localparam logic [2:0] PSEL_RST = 3'h0;
  // Value after reset of every data pointer
  localparam logic [15:0] PTR_RST = 16'h0000;

  // Addresses of the two registers that live in the mapped area
  localparam logic [7:0] AUX_PWR_CTRL_ADDR = 8'h88;
  localparam logic [7:0] PORT5_DIR_ADDR = 8'h91;

  // Stages of the reset synchroniser; the pin synchroniser has a fixed two
  localparam int SYNC_STAGES = 2;

endpackage

//--- rtl/xas_pointer_bank.sv
// Bank of selectable 16-bit data pointers
module xas_pointer_bank (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [xas_pkg::PSEL_W-1:0] sel,
  input wire logic wr,
  input wire logic [xas_pkg::ADDR_W-1:0] wdata,
  output logic [xas_pkg::ADDR_W-1:0] rdata
);
  import xas_pkg::*;

  // One word per data pointer
  logic [ADDR_W-1:0] ptr_q [PTR_COUNT];

  // Each entry loads only when it is the selected one
  genvar gi;
  generate
    for (gi = 0; gi < PTR_COUNT; gi++) begin : g_ptr
      // Write decode for this entry
      wire logic hit;
      assign hit = wr && (sel == PSEL_W'(gi));
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ptr_q[gi] <= PTR_RST;
        end else if (hit) begin
          ptr_q[gi] <= wdata;
        end
      end
    end
  endgenerate

  // Only the selected pointer is seen by the moves
  assign rdata = ptr_q[sel];

endmodule

//--- sim/xas_top_monitor.sv
// Watches the steering decisions at the block's ports
module xas_top_checker
  import xas_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic move_req,
  input wire logic move_use_ptr,
  input wire logic [7:0] move_index,
  input wire logic [7:0] sfr_addr,
  input wire logic move_done,
  input wire logic [15:0] move_addr,
  input wire logic move_onchip,
  input wire logic low_port_bus,
  input wire logic high_port_bus,
  input wire logic rd_strobe_active,
  input wire logic wr_strobe_active,
  input wire logic sfr_done,
  input wire logic sfr_to_mapped,
  input wire logic onchip_xdata_disable,
  input wire logic onchip_xdata_visible,
  input wire logic sfr_map_select,
  input wire logic [7:0] xdata_page_register,
  input wire logic external_access_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  // Either strobe fires on a bus cycle
  wire strb = rd_strobe_active || wr_strobe_active;
  // Decisions use state from the request cycle, hence $past below
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_done_after_req: assert property (move_req |=> move_done)
    else $error("move request not answered");
  a_disabled_external: assert property (
    move_done && $past(onchip_xdata_disable) |-> !move_onchip && low_port_bus && strb)
    else $error("disabled move kept on chip");
  a_range_onchip: assert property (
    move_done && !$past(onchip_xdata_disable) |-> move_onchip == (move_addr >= ONCHIP_START))
    else $error("on-chip range decode wrong");
  a_strobe_select: assert property (
    move_done |-> strb == (!move_onchip || $past(onchip_xdata_visible)))
    else $error("strobe activity wrong");
  a_low_port_mode: assert property (
    move_done |-> low_port_bus ==
      !(move_onchip && !$past(onchip_xdata_visible) && $past(external_access_sync)))
    else $error("low port mode wrong");
  a_high_port_mode: assert property (
    move_done |-> high_port_bus == ($past(move_use_ptr) && low_port_bus))
    else $error("high port mode wrong");
  a_index_addr: assert property (
    move_done && !$past(move_use_ptr) |->
      move_addr == {$past(xdata_page_register), $past(move_index)})
    else $error("paged address wrong");
  a_disable_sticky: assert property (!onchip_xdata_disable |=> !onchip_xdata_disable)
    else $error("disable bit set again");
  a_sfr_mapped: assert property (
    sfr_done |-> sfr_to_mapped == ($past(sfr_map_select) &&
      ($past(sfr_addr) == AUX_PWR_CTRL_ADDR || $past(sfr_addr) == PORT5_DIR_ADDR)))
    else $error("mapped routing wrong");
endmodule

bind xas_top xas_top_checker i_chk (.*);

//--- sim/xas_ext_mem.sv
// Far-side memory: counts every move that shows strobes on the bus
module xas_ext_mem (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic move_done,
  input wire logic rd_strobe_active,
  input wire logic wr_strobe_active,
  output logic [15:0] ext_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet on-chip moves never reach the far side
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_count <= 16'h0000;
    end else if (move_done && (rd_strobe_active || wr_strobe_active)) begin
      ext_count <= ext_count + 16'h0001;
    end
  end
endmodule

//--- sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import xas_pkg::*;
  // Design inputs
  logic mclk, rst_n, external_access_pin, ctl_wr, ctl_disable_wdata, ctl_visible_wdata;
  logic ctl_map_wdata, page_wr, psel_wr, ptr_wr, move_req, move_use_ptr, move_write, sfr_req;
  logic [7:0] page_wdata, move_index, sfr_addr;
  logic [2:0] psel_wdata;
  logic [15:0] ptr_wdata;
  // Design outputs
  logic move_done, move_onchip, low_port_bus, high_port_bus, rd_strobe_active;
  logic wr_strobe_active, sfr_done, sfr_to_mapped, sfr_to_standard, sfr_no_target;
  logic onchip_xdata_disable, onchip_xdata_visible, sfr_map_select, external_access_sync;
  logic core_rst_n;
  logic [15:0] move_addr, data_pointer, ext_count;
  logic [7:0] xdata_page_register;
  logic [2:0] pointer_select_register;
  // Reference state kept by the driver, and the prediction queues
  logic dis_m, vis_m, map_m;
  logic [7:0] page_m;
  logic [2:0] psel_m;
  logic [15:0] ext_m;
  logic [15:0] ptr_m [8];
  logic [15:0] adr [4];
  logic [20:0] got;
  logic [20:0] mq [$];
  logic [2:0] sq [$];
  int miscompares, total_checks, cyc;

  xas_top i_dut (.*);
  xas_ext_mem i_mem (.*);

  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // All request pulses in one assignment, so none is written twice per step
  task automatic go(input logic [5:0] p);
    {ctl_wr, page_wr, psel_wr, ptr_wr, move_req, sfr_req} = p;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge mclk);
      go(6'h00);
    end
  endtask
  task automatic ctl(input logic d, input logic v, input logic m);
    @(negedge mclk);
    {ctl_disable_wdata, ctl_visible_wdata, ctl_map_wdata} = {d, v, m};
    go(6'h20);
    dis_m = dis_m & d;
    vis_m = v;
    map_m = m;
  endtask
  task automatic page(input logic [7:0] p);
    @(negedge mclk);
    page_wdata = p;
    go(6'h10);
    page_m = p;
  endtask
  task automatic psel(input logic [2:0] s);
    @(negedge mclk);
    psel_wdata = s;
    go(6'h08);
    psel_m = s;
  endtask
  task automatic ptr(input logic [15:0] v);
    @(negedge mclk);
    ptr_wdata = v;
    go(6'h04);
    ptr_m[psel_m] = v;
  endtask
  // Predict one move from the reference state, then issue it
  task automatic mv(input logic up, input logic [7:0] i);
    logic [15:0] a;
    logic on, lo, st, w;
    w = 1'($urandom);
    a = up ? ptr_m[psel_m] : {page_m, i};
    on = !dis_m && a >= ONCHIP_START;
    lo = !(on && !vis_m && external_access_pin);
    st = !on || vis_m;
    ext_m = ext_m + {15'h0, st};
    mq.push_back({a, on, lo, up && lo, st && !w, st && w});
    @(negedge mclk);
    {move_use_ptr, move_write, move_index} = {up, w, i};
    go(6'h02);
  endtask
  task automatic sfr(input logic [7:0] a);
    logic hit;
    hit = a == AUX_PWR_CTRL_ADDR || a == PORT5_DIR_ADDR;
    sq.push_back({map_m && hit, !map_m, map_m && !hit});
    @(negedge mclk);
    sfr_addr = a;
    go(6'h01);
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Each decision pulse retires the oldest prediction
  always @(negedge mclk) begin
    if (move_done === 1'b1) begin
      got = {move_addr, move_onchip, low_port_bus, high_port_bus, rd_strobe_active,
        wr_strobe_active};
      chk(got, mq.pop_front());
    end
    if (sfr_done === 1'b1) begin
      chk({18'h0, sfr_to_mapped, sfr_to_standard, sfr_no_target}, {18'h0, sq.pop_front()});
    end
  end
  // Hang guard, well above the just under two hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    external_access_pin = 1'b0;
    {ctl_disable_wdata, ctl_visible_wdata, ctl_map_wdata, move_use_ptr, move_write} = 5'h00;
    {page_wdata, move_index, sfr_addr, psel_wdata, ptr_wdata} = '0;
    go(6'h00);
    {dis_m, vis_m, map_m, page_m, psel_m, ext_m} =
      {DISABLE_RST, VISIBLE_RST, MAP_SEL_RST, PAGE_RST, PSEL_RST, 16'h0000};
    ptr_m = '{default: PTR_RST};
    void'($urandom(58));
    adr = '{16'hF6FF, 16'hF700, 16'hFFFF, 16'($urandom) % 16'hF700};
    // Reset pin held low well past the synchroniser depth
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk(core_rst_n, 1'b0);
    rst_n = 1'b1;
    idle(3);
    // Reset values, taken from the package constants
    chk({core_rst_n, onchip_xdata_disable}, {1'b1, DISABLE_RST});
    chk({sfr_map_select, pointer_select_register}, {MAP_SEL_RST, PSEL_RST});
    chk(xdata_page_register, PAGE_RST);
    // Disabled: in-range moves still go out on the bus
    ptr(16'hFFFF);
    page(8'hF7);
    for (int p = 0; p < 2; p++) begin
      external_access_pin = p[0];
      // Visibility set while disabled must not pull moves on chip
      ctl(1'b1, p[0], 1'b0);
      idle(3);
      mv(1'b1, 8'h00);
      mv(1'b0, 8'($urandom));
    end
    ctl(1'b0, 1'b0, 1'b0);
    ctl(1'b1, 1'b0, 1'b0);
    idle(1);
    chk(onchip_xdata_disable, 1'b0);
    // Every mode, pin level and range boundary, each move right after a pointer or page write
    for (int p = 0; p < 4; p++) begin
      external_access_pin = p[1];
      ctl(1'b0, p[0], 1'b0);
      idle(3);
      chk({onchip_xdata_visible, external_access_sync}, {p[0], p[1]});
      for (int k = 0; k < 4; k++) begin
        ptr(adr[k]);
        mv(1'b1, 8'h00);
        page(adr[k][15:8]);
        mv(1'b0, adr[k][7:0]);
        chk(xdata_page_register, adr[k][15:8]);
      end
    end
    // Eight pointers hold distinct values; one is used at a time
    for (int k = 0; k < 8; k++) begin
      psel(3'(k));
      ptr(16'($urandom));
    end
    for (int k = 7; k >= 0; k--) begin
      psel(3'(k));
      mv(1'b1, 8'h00);
      idle(2);
      chk({pointer_select_register, data_pointer}, {3'(k), ptr_m[k]});
    end
    // Register area routing; map select stays put between accesses
    for (int m = 0; m < 2; m++) begin
      ctl(1'b0, 1'b0, m[0]);
      sfr(AUX_PWR_CTRL_ADDR);
      sfr(PORT5_DIR_ADDR);
      sfr(8'($urandom));
      idle(2);
      chk(sfr_map_select, m[0]);
    end
    idle(3);
    chk(21'(mq.size() + sq.size()), 21'h0);
    chk(ext_count, ext_m);
    // Reset in mid-run: the cleared disable bit must come back set
    @(negedge mclk);
    rst_n = 1'b0;
    idle(12);
    chk({core_rst_n, onchip_xdata_disable}, {1'b0, DISABLE_RST});
    rst_n = 1'b1;
    idle(3);
    chk({core_rst_n, onchip_xdata_disable}, {1'b1, DISABLE_RST});
    end_of_test();
  end
endmodule
